// >>> verilog/acf_pkg.sv
package acf_pkg;

  localparam int unsigned CODE_WIDTH    = 10;
  localparam int unsigned DIV_WIDTH     = 5;
  localparam int unsigned BIT_IDX_WIDTH = 4;

  localparam logic [7:0] ADDR_CONVERTER_CONFIG  = 8'hBC;
  localparam logic [7:0] ADDR_RESULT_LOW_BYTE   = 8'hBD;
  localparam logic [7:0] ADDR_RESULT_HIGH_BYTE  = 8'hBE;

  localparam int unsigned CFG_DIV_MSB  = 7;
  localparam int unsigned CFG_DIV_LSB  = 3;
  localparam int unsigned CFG_LJST_BIT = 2;
  localparam int unsigned CFG_8BIT_BIT = 1;
  localparam int unsigned CFG_GAIN_BIT = 0;

  localparam logic [7:0] CONVERTER_CONFIG_RESET = 8'hF8;
  localparam logic [7:0] RESULT_LOW_RESET       = 8'h00;
  localparam logic [7:0] RESULT_HIGH_RESET      = 8'h00;

  localparam logic [CODE_WIDTH-1:0]    TRIAL_FIRST     = 10'h200;
  localparam logic [BIT_IDX_WIDTH-1:0] BIT_IDX_MSB     = 4'h9;
  localparam logic [BIT_IDX_WIDTH-1:0] LAST_BIT_10BIT  = 4'h0;
  localparam logic [BIT_IDX_WIDTH-1:0] LAST_BIT_8BIT   = 4'h2;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } acf_sfr_req_type;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } acf_result_type;

endpackage

// >>> verilog/acf_sar_clkdiv.sv
`timescale 1ns/100ps
module acf_sar_clkdiv
  import acf_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic                 run,
  input  wire logic [DIV_WIDTH-1:0] divider,
  output logic                      sar_tick
);

  typedef struct packed {
    logic [DIV_WIDTH-1:0] count;
    logic                 tick;
  } acf_div_state_type;

  acf_div_state_type state;
  acf_div_state_type next_state;

  // one tick every divider+1 system clocks while running
  always_comb begin
    next_state      = state;
    next_state.tick = 1'b0;
    if (!run) begin
      next_state.count = '0;
    end else if (state.count == divider) begin
      next_state.count = '0;
      next_state.tick  = 1'b1;
    end else begin
      next_state.count = state.count + 5'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sar_tick = state.tick;

endmodule

// >>> verilog/acf_top.sv
// Functional notes
// - The conversion clock period is sar_clock_divider plus one system clock periods, divider in config bits 7:3.
// - Config bit 2 selects right (0) or left (1) justification of the 10-bit result.
// - Config bit 1 selects 8-bit conversions, in which the justify bit is ignored.
// - Config bit 0 selects input gain of one half (0) or one (1).
// - Right-justified 10-bit high byte reads zeros in 7:2 and the top two result bits in 1:0.
// - Left-justified 10-bit high byte reads the eight most significant result bits.
// - In 8-bit mode the high byte holds the whole 8-bit result.
// - Right-justified 10-bit low byte reads the eight least significant result bits.
// - Left-justified 10-bit low byte reads the two lowest result bits in 7:6 and zeros below.
// - In 8-bit mode the low byte reads all zeros.
// - An 8-bit conversion takes two fewer conversion clock cycles than a 10-bit one.
// - The result bytes load at the end of each completed (not aborted) conversion and the done flag is set with them.
// - With converter_enable low no conversion runs; with it high the converter is active.
`timescale 1ns/100ps
module acf_top
  import acf_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire acf_sfr_req_type       sfr_req,
  output logic [7:0]                 sfr_rdata,
  input  wire logic                  converter_enable,
  input  wire logic                  conversion_start,
  input  wire logic                  comparator_above,
  input  wire logic                  done_flag_clear,
  output logic [CODE_WIDTH-1:0]      sar_trial_code,
  output logic                       conversion_busy,
  output logic                       conversion_done_flag,
  output logic                       gain_select,
  output logic                       sar_conversion_clock
);

  typedef enum logic [1:0] {
    PHASE_IDLE    = 2'b00,
    PHASE_CONVERT = 2'b01
  } acf_phase_type;

  typedef struct packed {
    logic [7:0]               config_reg;
    acf_result_type           result;
    logic [7:0]               rdata;
    logic                     busy;
    logic                     done_flag;
    logic [BIT_IDX_WIDTH-1:0] bit_idx;
    logic [CODE_WIDTH-1:0]    trial;
    logic                     eight_bit_mode_enable;
    logic                     left_justify_select;
    logic [DIV_WIDTH-1:0]     sar_clock_divider;
    logic                     sar_clk_q;
    acf_phase_type            phase;
  } acf_state_type;

  acf_state_type state;
  acf_state_type next_state;
  logic          sar_tick;

  // place a finished code into the two result bytes
  function automatic acf_result_type format_result(
    input logic [CODE_WIDTH-1:0] code,
    input logic                  eight_bit,
    input logic                  left_just
  );
    acf_result_type r;
    r = '0;
    if (eight_bit) begin
      r.high = code[9:2];
      r.low  = 8'h00;
    end else if (left_just) begin
      r.high = code[9:2];
      r.low  = {code[1:0], 6'h00};
    end else begin
      r.high = {6'h00, code[9:8]};
      r.low  = code[7:0];
    end
    return r;
  endfunction

  // decide the bit under test, then raise the next lower trial bit unless this was the last one
  function automatic logic [CODE_WIDTH-1:0] sar_step(
    input logic [CODE_WIDTH-1:0]    code,
    input logic [BIT_IDX_WIDTH-1:0] idx,
    input logic                     keep,
    input logic                     last
  );
    logic [CODE_WIDTH-1:0] c;
    c = code;
    if (!keep) begin
      c[idx] = 1'b0;
    end
    if (!last) begin
      c[idx - 4'h1] = 1'b1;
    end
    return c;
  endfunction

  // one-hot register select: bit 0 config, bit 1 low byte, bit 2 high byte
  function automatic logic [2:0] reg_select(
    input logic [7:0] addr
  );
    logic [2:0] sel;
    sel = 3'h0;
    case (addr)
      ADDR_CONVERTER_CONFIG: sel = 3'h1;
      ADDR_RESULT_LOW_BYTE:  sel = 3'h2;
      ADDR_RESULT_HIGH_BYTE: sel = 3'h4;
      default:               sel = 3'h0;
    endcase
    return sel;
  endfunction

  function automatic logic [7:0] read_mux(
    input logic [7:0]     addr,
    input logic [7:0]     cfg,
    input acf_result_type res
  );
    logic [2:0] sel;
    logic [7:0] d;
    sel = reg_select(addr);
    d   = 8'h00;
    if (sel[0]) begin
      d = cfg;
    end else if (sel[1]) begin
      d = res.low;
    end else if (sel[2]) begin
      d = res.high;
    end
    return d;
  endfunction

  acf_sar_clkdiv u_clkdiv (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .run      (state.busy),
    .divider  (state.sar_clock_divider),
    .sar_tick (sar_tick)
  );

  always_comb begin
    logic [CODE_WIDTH-1:0]    decided;
    logic [BIT_IDX_WIDTH-1:0] last_bit;
    logic [2:0]               wr_sel;
    last_bit   = state.eight_bit_mode_enable ? LAST_BIT_8BIT : LAST_BIT_10BIT;
    decided    = sar_step(state.trial, state.bit_idx, comparator_above, state.bit_idx == last_bit);
    wr_sel     = reg_select(sfr_req.addr);
    next_state = state;
    next_state.sar_clk_q = sar_tick;

    if (sfr_req.rd_en) begin
      next_state.rdata = read_mux(sfr_req.addr, state.config_reg, state.result);
    end

    // software writes; a conversion load below takes priority on the result bytes
    if (sfr_req.wr_en && wr_sel[0]) begin
      next_state.config_reg = sfr_req.wdata;
    end
    if (sfr_req.wr_en && wr_sel[1]) begin
      next_state.result.low = sfr_req.wdata;
    end
    if (sfr_req.wr_en && wr_sel[2]) begin
      next_state.result.high = sfr_req.wdata;
    end

    if (done_flag_clear) begin
      next_state.done_flag = 1'b0;
    end

    // conversion sequencing; enable low aborts without loading results or setting the flag
    case (state.phase)
      PHASE_IDLE: begin
        if (converter_enable && conversion_start) begin
          next_state.phase                 = PHASE_CONVERT;
          next_state.busy                  = 1'b1;
          next_state.trial                 = TRIAL_FIRST;
          next_state.bit_idx               = BIT_IDX_MSB;
          next_state.sar_clock_divider     = state.config_reg[CFG_DIV_MSB:CFG_DIV_LSB];
          next_state.eight_bit_mode_enable = state.config_reg[CFG_8BIT_BIT];
          next_state.left_justify_select   = state.config_reg[CFG_LJST_BIT];
        end
      end
      PHASE_CONVERT: begin
        if (!converter_enable) begin
          next_state.phase = PHASE_IDLE;
          next_state.busy  = 1'b0;
        end else if (sar_tick) begin
          next_state.trial = decided;
          if (state.bit_idx == last_bit) begin
            next_state.phase     = PHASE_IDLE;
            next_state.busy      = 1'b0;
            next_state.result    = format_result(decided, state.eight_bit_mode_enable,
                                                 state.left_justify_select);
            next_state.done_flag = 1'b1;
          end else begin
            next_state.bit_idx = state.bit_idx - 4'h1;
          end
        end
      end
      default: begin
        next_state.phase = PHASE_IDLE;
        next_state.busy  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state             <= '0;
      state.config_reg  <= CONVERTER_CONFIG_RESET;
      state.result.low  <= RESULT_LOW_RESET;
      state.result.high <= RESULT_HIGH_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign sfr_rdata            = state.rdata;
  assign sar_trial_code       = state.trial;
  assign conversion_busy      = state.busy;
  assign conversion_done_flag = state.done_flag;
  assign gain_select          = state.config_reg[CFG_GAIN_BIT];
  assign sar_conversion_clock = state.sar_clk_q;

endmodule

// >>> sim/acf_top_assertions.sv
`timescale 1ns/100ps
module acf_top_assertions
  import acf_pkg::*;
(
  input wire logic            ref_clk,
  input wire logic            rst_n,
  input wire acf_sfr_req_type sfr_req,
  input wire logic            converter_enable,
  input wire logic            conversion_start,
  input wire logic            done_flag_clear,
  input wire logic            conversion_busy,
  input wire logic            conversion_done_flag,
  input wire logic            gain_select,
  input wire logic            sar_conversion_clock
);
  logic [7:0] cfg;
  logic [7:0] lat;
  logic [9:0] cnt;
  logic [9:0] len;
  wire logic  take = conversion_start && converter_enable && !conversion_busy;
  // busy lasts one cycle more than the conversion clock periods it spans
  assign len = (lat[CFG_8BIT_BIT] ? 10'h008 : 10'h00A) * ({5'h00, lat[7:3]} + 10'h001) + 10'h001;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cfg <= CONVERTER_CONFIG_RESET;
      lat <= 8'h00;
      cnt <= 10'h000;
    end else begin
      if (sfr_req.wr_en && sfr_req.addr == ADDR_CONVERTER_CONFIG) cfg <= sfr_req.wdata;
      if (take) lat <= cfg;
      cnt <= conversion_busy ? cnt + 10'h001 : 10'h000;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_START: assert property (take |=> conversion_busy) else $error("start not taken");
  AST_OFF: assert property (!converter_enable |=> !conversion_busy) else $error("busy while off");
  AST_IDLE: assert property (!conversion_busy && !conversion_start |=> !conversion_busy) else $error("busy untriggered");
  AST_LEN: assert property ($fell(conversion_busy) && $past(converter_enable) |-> cnt == len) else $error("bad length");
  AST_DONE: assert property ($fell(conversion_busy) && $past(converter_enable) |-> conversion_done_flag) else $error("no flag");
  AST_NOSET: assert property (!converter_enable && !conversion_done_flag |=> !conversion_done_flag) else $error("flag off");
  AST_CLR: assert property (done_flag_clear && !conversion_busy |=> !conversion_done_flag) else $error("flag kept");
  AST_HOLD: assert property (conversion_done_flag && !done_flag_clear |=> conversion_done_flag) else $error("flag lost");
  AST_GAIN: assert property (sfr_req.wr_en && sfr_req.addr == ADDR_CONVERTER_CONFIG |=>
    gain_select == $past(sfr_req.wdata[CFG_GAIN_BIT])) else $error("gain wrong");
  AST_SCLK: assert property (sar_conversion_clock |-> $past(conversion_busy, 2)) else $error("clock while idle");
endmodule
bind acf_top acf_top_assertions u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .sfr_req(sfr_req),
  .converter_enable(converter_enable), .conversion_start(conversion_start), .done_flag_clear(done_flag_clear),
  .conversion_busy(conversion_busy), .conversion_done_flag(conversion_done_flag), .gain_select(gain_select),
  .sar_conversion_clock(sar_conversion_clock));

// >>> sim/adc_config_and_result_format_test.sv
`timescale 1ns/100ps
module adc_config_and_result_format_test
  import acf_pkg::*;
;
  logic            ref_clk = 1'b0;
  logic            rst_n = 1'b0;
  acf_sfr_req_type sfr_req = '0;
  logic            converter_enable = 1'b1;
  logic            conversion_start = 1'b0;
  logic            done_flag_clear = 1'b0;
  logic [9:0]      target = 10'h000;
  logic [9:0]      sar_trial_code;
  logic [7:0]      sfr_rdata;
  logic [7:0]      h;
  logic [7:0]      c;
  logic [7:0]      w8;
  logic            conversion_busy;
  logic            conversion_done_flag;
  logic            gain_select;
  logic            comparator_above;
  logic            sar_conversion_clock;
  int              seed = 32'hDC389749;
  int              miscompares = 0;
  int              total_checks = 0;
  int              cyc = 0;
  int              pulses = 0;
  int              p0 = 0;
  assign comparator_above = target >= sar_trial_code;
  always #5 ref_clk = ~ref_clk;
  acf_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .converter_enable(converter_enable), .conversion_start(conversion_start), .comparator_above(comparator_above),
    .done_flag_clear(done_flag_clear), .sar_trial_code(sar_trial_code), .conversion_busy(conversion_busy),
    .conversion_done_flag(conversion_done_flag), .gain_select(gain_select),
    .sar_conversion_clock(sar_conversion_clock));
  function automatic logic [15:0] fmt(input logic [9:0] v, input logic eb, input logic lj);
    return eb ? {v[9:2], 8'h00} : (lj ? {v, 6'h00} : {6'h00, v});
  endfunction
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) #1 sfr_req = '{w, ~w, a, d};
    @(posedge ref_clk) #1 sfr_req = '0;
    c = sfr_rdata;
  endtask
  // one-cycle pulse on the clear input (clr high) or on the start input (clr low)
  task automatic pulse(input logic clr);
    @(posedge ref_clk) #1 {done_flag_clear, conversion_start} = {clr, ~clr};
    @(posedge ref_clk) #1 {done_flag_clear, conversion_start} = 2'b00;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (sar_conversion_clock === 1'b1) pulses++;
    if (cyc == 20000) begin
      miscompares++;
      close_out;
    end
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    // config, low, high, then an unmapped address
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, 8'hBC + 8'(i), 8'h00);
      chk("reset", c, i == 0 ? CONVERTER_CONFIG_RESET : 8'h00);
    end
    for (int i = 0; i < 12; i++) begin
      // divider kept at one or more
      w8 = {5'(1 + {$random(seed)} % 4), i[0], i[1], i[2]};
      if (i == 11) w8[7:3] = 5'h1F;
      target = i == 0 ? 10'h3FF : (i == 1 ? 10'h000 : 10'($random(seed)));
      acc(1'b1, ADDR_CONVERTER_CONFIG, w8);
      chk("gain", gain_select, i[2]);
      acc(1'b0, ADDR_CONVERTER_CONFIG, 8'h00);
      chk("cfg", c, w8);
      p0 = pulses;
      pulse(1'b0);
      // flipped divider, mode and justify settings must not touch the running conversion (gain follows at once); divider stays nonzero
      acc(1'b1, ADDR_CONVERTER_CONFIG, w8 ^ 8'h47);
      for (int k = 0; k < 400 && conversion_done_flag !== 1'b1; k++) @(posedge ref_clk) #1;
      chk("done", conversion_done_flag, 1'b1);
      acc(1'b0, ADDR_RESULT_HIGH_BYTE, 8'h00);
      h = c;
      acc(1'b0, ADDR_RESULT_LOW_BYTE, 8'h00);
      chk("result", {h, c}, fmt(target, i[1], i[0]));
      chk("sar clocks", 16'(pulses - p0), i[1] ? 16'h0008 : 16'h000A);
      pulse(1'b1);
      chk("clear", conversion_done_flag, 1'b0);
    end
    converter_enable = 1'b0;
    pulse(1'b0);
    chk("off", conversion_busy, 1'b0);
    converter_enable = 1'b1;
    pulse(1'b0);
    chk("busy", conversion_busy, 1'b1);
    converter_enable = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk("abort", {conversion_busy, conversion_done_flag}, 2'b00);
    close_out;
  end
endmodule
